// >>> hw/txabt_unit.sv
// Transaction abort, commit, debug rollback and suspend tracking unit
`timescale 1ns/1ps
`include "txabt_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Status bit 0 set only when the explicit abort instruction caused the abort.
// - Status bit 1 means retry may succeed; never set with bit 0.
// - Status bit 2 set on conflicting access by another logical processor.
// - Status bit 3 set when a tracking buffer overflow caused the abort.
// - Status bit 4 set when a debug or breakpoint exception was hit.
// - Status bit 5 set when aborting inside a nested region.
// - Bits 23:6 read zero; bits 31:24 hold abort argument only with bit 0.
// - Status reports causes only; causeless aborts may give all zeros.
// - Commit publishes all stores at once with a full fence; begin no fence.
// - Abort discards every buffered store; none is ever made visible.
// - Default debug abort restores state, sets bit 4, jumps to fallback.
// - Advanced debug needs debug-control bit 11 and msr bit 15 both set.
// - Advanced debug abort rolls back before begin, restores status, raises debug.
// - Delivering that debug exception clears debug-status bit 16.
// - Suspend stops adding loads to read set; resume restarts it.
// - Loads only seen while suspended stay untracked; others stay tracked.
// - Begin or end while suspended aborts the transaction.
// - Suspend while already suspended aborts the transaction.
// - Only commit updates architectural state; abort leaves nothing visible.
// - Explicit abort, id query, spin-wait and enclave leaves always abort.
// - Direction instructions abort only if they change the direction flag.
// - Nesting is one region; any abort restores to outermost begin.
module txabt_unit #(
   parameter int NEST_MAX = 7,
   parameter int NEST_W   = 3
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone classic slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   output logic                      wb_err_o,
   // Core instruction stream
   input  wire logic                 op_valid_i,
   input  wire txabt_pkg::txabt_op_t op_code_i,
   input  wire logic [7:0]           op_arg_i,
   input  wire logic [31:0]          status_word_i,
   // Runtime abort causes
   input  wire logic                 conflict_i,
   input  wire logic                 overflow_i,
   input  wire logic                 debug_exc_i,
   input  wire logic                 bp_exc_i,
   input  wire logic                 retry_hint_i,
   // Load tracking and store publication
   output logic                      read_set_add_o,
   output logic                      store_buffer_o,
   output logic                      commit_o,
   output logic                      fence_o,
   output logic                      discard_o,
   output logic                      redirect_fallback_o,
   output logic                      rollback_begin_o,
   output logic                      deliver_debug_o,
   output logic                      in_txn_o,
   output logic                      direction_flag_o,
   output logic [31:0]               abort_status_word_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode of instruction and abort conditions
   txabt_pkg::txabt_state_t state_reg;
   logic [NEST_W-1:0]       depth_reg;
   logic                    df_reg;
   logic [31:0]             debug_control_reg;
   logic [31:0]             debug_control_msr;
   logic [31:0]             debug_status_reg;
   logic [31:0]             cause_reg;
   logic [31:0]             saved_status_reg;
   logic [31:0]             events_reg;
   logic [31:0]             commits_reg;
   logic                    in_txn;
   logic                    op_begin;
   logic                    op_end;
   logic                    instr_abort;
   logic                    dbg_hit;
   logic                    abort;
   logic                    adv_debug;
   logic                    commit;
   logic [31:0]             cause_next;
   logic                    wb_hit;
   logic                    wb_map;

   assign in_txn   = (state_reg != txabt_pkg::TXABT_IDLE);
   assign op_begin = op_valid_i && (op_code_i == txabt_pkg::TXABT_OP_BEGIN);
   assign op_end   = op_valid_i && (op_code_i == txabt_pkg::TXABT_OP_END);
   assign dbg_hit  = in_txn && (debug_exc_i || bp_exc_i);
   assign adv_debug = debug_control_reg[`TXABT_DBGCTL_ADV]
                      && debug_control_msr[`TXABT_MSR_ADV];

   // Instruction-caused aborts
   always_comb begin
      instr_abort = 1'b0;
      if (op_valid_i && in_txn) begin
         case (op_code_i)
            txabt_pkg::TXABT_OP_ABORT,
            txabt_pkg::TXABT_OP_IDQUERY,
            txabt_pkg::TXABT_OP_SPINWAIT,
            txabt_pkg::TXABT_OP_ENCL_SUP,
            txabt_pkg::TXABT_OP_ENCL_USR: instr_abort = 1'b1;
            txabt_pkg::TXABT_OP_CLEAR_DIR: instr_abort = df_reg;
            txabt_pkg::TXABT_OP_SET_DIR: instr_abort = !df_reg;
            txabt_pkg::TXABT_OP_BEGIN: begin
               instr_abort = (state_reg == txabt_pkg::TXABT_SUSPENDED)
                             || (depth_reg == NEST_W'(NEST_MAX));
            end
            txabt_pkg::TXABT_OP_END: begin
               instr_abort = (state_reg == txabt_pkg::TXABT_SUSPENDED);
            end
            txabt_pkg::TXABT_OP_SUSPEND: begin
               instr_abort = (state_reg == txabt_pkg::TXABT_SUSPENDED);
            end
            default: instr_abort = 1'b0;
         endcase
      end
   end

   assign abort  = in_txn && (instr_abort || conflict_i || overflow_i || dbg_hit);
   assign commit = !abort && op_end && (depth_reg == NEST_W'(1));

   // Cause word assembly
   always_comb begin
      cause_next = 32'h00000000;
      if (op_valid_i && op_code_i == txabt_pkg::TXABT_OP_ABORT) begin
         cause_next[`TXABT_BIT_EXPLICIT] = 1'b1;
         cause_next[31:`TXABT_ARG_LSB] = op_arg_i;
      end else begin
         cause_next[`TXABT_BIT_RETRY] = retry_hint_i || conflict_i;
      end
      cause_next[`TXABT_BIT_CONFLICT] = conflict_i;
      cause_next[`TXABT_BIT_OVERFLOW] = overflow_i;
      cause_next[`TXABT_BIT_DEBUG] = dbg_hit;
      cause_next[`TXABT_BIT_NESTED] = (depth_reg > NEST_W'(1));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transaction state and nesting depth
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= txabt_pkg::TXABT_IDLE;
         depth_reg <= '0;
      end else if (abort) begin
         state_reg <= txabt_pkg::TXABT_IDLE;
         depth_reg <= '0;
      end else if (op_begin) begin
         if (!in_txn) begin
            state_reg <= txabt_pkg::TXABT_ACTIVE;
         end
         depth_reg <= depth_reg + NEST_W'(1);
      end else if (op_end && in_txn) begin
         depth_reg <= depth_reg - NEST_W'(1);
         if (commit) begin
            state_reg <= txabt_pkg::TXABT_IDLE;
         end
      end else if (op_valid_i && op_code_i == txabt_pkg::TXABT_OP_SUSPEND && in_txn) begin
         state_reg <= txabt_pkg::TXABT_SUSPENDED;
      end else if (op_valid_i && op_code_i == txabt_pkg::TXABT_OP_RESUME
                   && state_reg == txabt_pkg::TXABT_SUSPENDED) begin
         state_reg <= txabt_pkg::TXABT_ACTIVE;
      end
   end

   // Direction flag updated by direction instructions
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         df_reg <= `TXABT_DF_RST;
      end else if (!abort && op_valid_i) begin
         if (op_code_i == txabt_pkg::TXABT_OP_CLEAR_DIR) begin
            df_reg <= 1'b0;
         end else if (op_code_i == txabt_pkg::TXABT_OP_SET_DIR) begin
            df_reg <= 1'b1;
         end
      end
   end

   // Status word snapshot at outermost begin, cause on abort
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         saved_status_reg <= 32'h00000000;
         cause_reg        <= 32'h00000000;
      end else begin
         if (op_begin && !in_txn) begin
            saved_status_reg <= status_word_i;
         end
         if (abort) begin
            cause_reg <= (dbg_hit && adv_debug) ? saved_status_reg : cause_next;
         end
      end
   end

   // Debug status: hardware clear wins over software write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         debug_status_reg <= `TXABT_DBGSTAT_RST;
      end else begin
         if (wb_hit && wb_we_i && wb_adr_i == `TXABT_OFS_DBGSTAT) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) begin
                  debug_status_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
               end
            end
         end
         if (abort && dbg_hit && adv_debug) begin
            debug_status_reg[`TXABT_DBGSTAT_TXN] <= 1'b0;
         end
      end
   end

   // Sticky event flags, set wins over write-one-to-clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         events_reg  <= 32'h00000000;
         commits_reg <= 32'h00000000;
      end else begin
         events_reg <= (wb_hit && wb_we_i && wb_adr_i == `TXABT_OFS_EVENT)
                       ? (events_reg & ~wb_dat_i) | {30'h0, commit, abort}
                       : events_reg | {30'h0, commit, abort};
         if (commit) begin
            commits_reg <= commits_reg + 32'h00000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone slave: one wait state, err on unmapped address
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   always_comb begin
      case (wb_adr_i)
         `TXABT_OFS_CAUSE, `TXABT_OFS_STATE, `TXABT_OFS_DBGCTL,
         `TXABT_OFS_DBGSTAT, `TXABT_OFS_EVENT, `TXABT_OFS_COMMITS: wb_map = 1'b1;
         default: wb_map = 1'b0;
      endcase
   end

   // Debug control pair: low half control register, high half msr
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         debug_control_reg <= 32'h00000000;
         debug_control_msr <= 32'h00000000;
      end else if (wb_hit && wb_we_i && wb_adr_i == `TXABT_OFS_DBGCTL) begin
         if (wb_sel_i[1]) begin
            debug_control_reg[15:8] <= wb_dat_i[15:8];
         end
         if (wb_sel_i[0]) begin
            debug_control_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[3]) begin
            debug_control_msr[15:8] <= wb_dat_i[31:24];
         end
         if (wb_sel_i[2]) begin
            debug_control_msr[7:0] <= wb_dat_i[23:16];
         end
      end
   end

   // Acknowledge and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_hit && wb_map;
         wb_err_o <= wb_hit && !wb_map;
         wb_dat_o <= 32'h00000000;
         if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
               `TXABT_OFS_CAUSE: wb_dat_o <= cause_reg;
               `TXABT_OFS_STATE: wb_dat_o <= {24'h0, depth_reg, 2'b0, df_reg, state_reg};
               `TXABT_OFS_DBGCTL: begin
                  wb_dat_o <= {debug_control_msr[15:0], debug_control_reg[15:0]};
               end
               `TXABT_OFS_DBGSTAT: wb_dat_o <= debug_status_reg;
               `TXABT_OFS_EVENT: wb_dat_o <= events_reg;
               `TXABT_OFS_COMMITS: wb_dat_o <= commits_reg;
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outcome pulses to the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         commit_o            <= 1'b0;
         fence_o             <= 1'b0;
         discard_o           <= 1'b0;
         redirect_fallback_o <= 1'b0;
         rollback_begin_o    <= 1'b0;
         deliver_debug_o     <= 1'b0;
      end else begin
         commit_o            <= commit;
         fence_o             <= commit;
         discard_o           <= abort;
         redirect_fallback_o <= abort && !(dbg_hit && adv_debug);
         rollback_begin_o    <= abort && dbg_hit && adv_debug;
         deliver_debug_o     <= abort && dbg_hit && adv_debug;
      end
   end

   // Loads tracked only while active (in a transaction, not suspended); stores buffered while in a transaction
   assign read_set_add_o = op_valid_i && (op_code_i == txabt_pkg::TXABT_OP_LOAD)
                           && (state_reg == txabt_pkg::TXABT_ACTIVE);
   assign store_buffer_o = op_valid_i && (op_code_i == txabt_pkg::TXABT_OP_STORE)
                           && in_txn;
   assign in_txn_o            = in_txn;
   assign direction_flag_o    = df_reg;
   assign abort_status_word_o = cause_reg;

endmodule

// >>> pkg/txabt_params.svh
// Offsets, field positions and reset values for the transaction abort unit
`ifndef TXABT_PARAMS_SVH
`define TXABT_PARAMS_SVH
`define TXABT_OFS_CAUSE      8'h00
`define TXABT_OFS_STATE      8'h04
`define TXABT_OFS_DBGCTL     8'h08
`define TXABT_OFS_DBGSTAT    8'h0c
`define TXABT_OFS_EVENT      8'h10
`define TXABT_OFS_COMMITS    8'h14
`define TXABT_BIT_EXPLICIT   0
`define TXABT_BIT_RETRY      1
`define TXABT_BIT_CONFLICT   2
`define TXABT_BIT_OVERFLOW   3
`define TXABT_BIT_DEBUG      4
`define TXABT_BIT_NESTED     5
`define TXABT_ARG_LSB        24
`define TXABT_DBGCTL_ADV     11
`define TXABT_MSR_ADV        15
`define TXABT_DBGSTAT_TXN    16
`define TXABT_DBGCTL_MSR_LSB 16
`define TXABT_DBGSTAT_RST    32'hffff0ff0
`define TXABT_DF_RST         1'b0
`endif

// >>> pkg/txabt_pkg.sv
// Types for the transaction abort unit
package txabt_pkg;
   // Instruction codes presented by the core
   typedef enum logic [3:0] {
      TXABT_OP_NONE,
      TXABT_OP_BEGIN,
      TXABT_OP_END,
      TXABT_OP_ABORT,
      TXABT_OP_SUSPEND,
      TXABT_OP_RESUME,
      TXABT_OP_IDQUERY,
      TXABT_OP_SPINWAIT,
      TXABT_OP_ENCL_SUP,
      TXABT_OP_ENCL_USR,
      TXABT_OP_CLEAR_DIR,
      TXABT_OP_SET_DIR,
      TXABT_OP_LOAD,
      TXABT_OP_STORE
   } txabt_op_t;
   typedef enum logic [1:0] {
      TXABT_IDLE,
      TXABT_ACTIVE,
      TXABT_SUSPENDED
   } txabt_state_t;
endpackage

// >>> verif/txabt_unit_properties.sv
// Concurrent assertions for the transaction abort unit
`timescale 1ns/1ps
module txabt_unit_chk (
   input logic                 clk_i,
   input logic                 rst_i,
   input logic                 op_valid_i,
   input txabt_pkg::txabt_op_t op_code_i,
   input logic [7:0]           op_arg_i,
   input logic                 conflict_i,
   input logic                 overflow_i,
   input logic                 debug_exc_i,
   input logic                 bp_exc_i,
   input logic                 read_set_add_o,
   input logic                 commit_o,
   input logic                 fence_o,
   input logic                 discard_o,
   input logic                 redirect_fallback_o,
   input logic                 rollback_begin_o,
   input logic                 deliver_debug_o,
   input logic                 in_txn_o,
   input logic                 direction_flag_o,
   input logic [31:0]          abort_status_word_o
);
   logic susp_reg;
   logic top;
   logic quiet;
   // Instruction seen inside a transaction
   assign top = op_valid_i && in_txn_o;
   // No runtime abort cause pending
   assign quiet = !(conflict_i || overflow_i || debug_exc_i || bp_exc_i);
   // Shadow of the suspend region, cleared whenever no transaction runs
   always_ff @(posedge clk_i) begin
      if (rst_i || !in_txn_o) susp_reg <= 1'b0;
      else if (op_valid_i && op_code_i == txabt_pkg::TXABT_OP_SUSPEND) susp_reg <= 1'b1;
      else if (op_valid_i && op_code_i == txabt_pkg::TXABT_OP_RESUME) susp_reg <= 1'b0;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   chk_retry_excl: assert property (abort_status_word_o[0] |-> !abort_status_word_o[1])
      else $error("retry and explicit bits both set");
   chk_explicit_arg: assert property (top && quiet
      && op_code_i == txabt_pkg::TXABT_OP_ABORT |=>
      discard_o && abort_status_word_o[0] && abort_status_word_o[31:24] == $past(op_arg_i))
      else $error("explicit abort word wrong");
   chk_reserved_zero: assert property (discard_o && !rollback_begin_o
      && !abort_status_word_o[0] |-> abort_status_word_o[31:6] == 26'h0)
      else $error("reserved status bits set");
   chk_always_abort: assert property (top && op_code_i inside {txabt_pkg::TXABT_OP_IDQUERY,
      txabt_pkg::TXABT_OP_SPINWAIT, txabt_pkg::TXABT_OP_ENCL_SUP, txabt_pkg::TXABT_OP_ENCL_USR}
      |=> discard_o && !in_txn_o && !commit_o)
      else $error("listed instruction did not abort");
   chk_commit_fence: assert property (commit_o |-> fence_o && !discard_o && !in_txn_o)
      else $error("commit without fence");
   chk_load_track: assert property (op_valid_i && op_code_i == txabt_pkg::TXABT_OP_LOAD
      |-> read_set_add_o == (in_txn_o && !susp_reg))
      else $error("read set tracking wrong");
   chk_susp_abort: assert property (top && susp_reg && op_code_i inside
      {txabt_pkg::TXABT_OP_BEGIN, txabt_pkg::TXABT_OP_END, txabt_pkg::TXABT_OP_SUSPEND}
      |=> discard_o && !in_txn_o)
      else $error("no abort inside suspend region");
   chk_dir_keep: assert property (top && ((op_code_i == txabt_pkg::TXABT_OP_SET_DIR
      && direction_flag_o) || (op_code_i == txabt_pkg::TXABT_OP_CLEAR_DIR && !direction_flag_o))
      && quiet |=> !discard_o && in_txn_o)
      else $error("unchanged direction flag aborted");
   chk_conflict_bit: assert property (in_txn_o && conflict_i && !op_valid_i
      |=> discard_o ##0 abort_status_word_o[2])
      else $error("conflict bit missing");
   chk_overflow_bit: assert property (in_txn_o && overflow_i && !op_valid_i
      |=> discard_o && abort_status_word_o[3])
      else $error("overflow bit missing");
   chk_debug_path: assert property (in_txn_o && (debug_exc_i || bp_exc_i) |=> discard_o &&
      ((redirect_fallback_o && abort_status_word_o[4]) || (rollback_begin_o && deliver_debug_o)))
      else $error("debug abort outcome wrong");
endmodule
bind txabt_unit txabt_unit_chk u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
   .op_arg_i(op_arg_i), .conflict_i(conflict_i), .overflow_i(overflow_i),
   .debug_exc_i(debug_exc_i), .bp_exc_i(bp_exc_i), .read_set_add_o(read_set_add_o),
   .commit_o(commit_o), .fence_o(fence_o), .discard_o(discard_o),
   .redirect_fallback_o(redirect_fallback_o), .rollback_begin_o(rollback_begin_o),
   .deliver_debug_o(deliver_debug_o), .in_txn_o(in_txn_o),
   .direction_flag_o(direction_flag_o), .abort_status_word_o(abort_status_word_o)
);

// >>> verif/tb_txabt_unit.sv
// Self-checking testbench for the transaction abort unit
`timescale 1ns/1ps
`include "txabt_params.svh"
module tb_txabt_unit;
   logic                 clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, op_valid_i, comb_q;
   logic [7:0]           wb_adr_i, op_arg_i;
   logic [3:0]           wb_sel_i;
   logic [31:0]          wb_dat_i, wb_dat_o, status_word_i, word_o, rd;
   logic                 wb_ack_o, wb_err_o, rs_o, sb_o, commit_o, fence_o, err;
   logic                 discard_o, redir_o, rollback_o, deliver_o, in_txn_o, df_o;
   logic [4:0]           ev;
   txabt_pkg::txabt_op_t op_code_i;
   int                   error_cnt = 0;
   int                   compares = 0;
   ////////////////////////////////////////////////////////////////////////////
   txabt_unit uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
      .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_arg_i(op_arg_i),
      .status_word_i(status_word_i), .conflict_i(ev[0]), .overflow_i(ev[1]),
      .debug_exc_i(ev[2]), .bp_exc_i(ev[3]), .retry_hint_i(ev[4]), .read_set_add_o(rs_o),
      .store_buffer_o(sb_o), .commit_o(commit_o), .fence_o(fence_o), .discard_o(discard_o),
      .redirect_fallback_o(redir_o), .rollback_begin_o(rollback_o), .deliver_debug_o(deliver_o),
      .in_txn_o(in_txn_o), .direction_flag_o(df_o), .abort_status_word_o(word_o)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      if (error_cnt == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Classic single bus cycle, held until ack or err
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hf;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (!(wb_ack_o || wb_err_o) && n < 20);
      chk(wb_ack_o | wb_err_o, 1'b1);
      if (!(wb_ack_o || wb_err_o)) close_out();
      rd = wb_dat_o;
      err = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   // One instruction with runtime events; comb_q holds load or store tracking
   task automatic op(input txabt_pkg::txabt_op_t c, input logic [4:0] e = 5'h0,
                     input logic [31:0] a = 32'h0);
      @(posedge clk_i);
      op_valid_i <= (c != txabt_pkg::TXABT_OP_NONE);
      op_code_i <= c;
      ev <= e;
      op_arg_i <= a[7:0];
      status_word_i <= a;
      #1;
      comb_q = (c == txabt_pkg::TXABT_OP_LOAD) ? rs_o : sb_o;
      @(posedge clk_i);
      op_valid_i <= 1'b0;
      ev <= 5'h0;
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic s_reset;
      chk({in_txn_o, discard_o, commit_o, df_o, word_o}, 36'h0);
      wb(1'b0, `TXABT_OFS_DBGSTAT, 32'h0);
      chk(rd, `TXABT_DBGSTAT_RST);
      wb(1'b1, `TXABT_OFS_CAUSE, 32'hffffffff);
      wb(1'b0, `TXABT_OFS_CAUSE, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
   endtask
   task automatic s_explicit;
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_LOAD);
      chk(comb_q, 1'b1);
      op(txabt_pkg::TXABT_OP_STORE);
      chk(comb_q, 1'b1);
      op(txabt_pkg::TXABT_OP_ABORT, 5'h0, 32'hc3);
      chk({discard_o, redir_o, in_txn_o, commit_o}, 4'b1100);
      chk(word_o, 32'hc3000001);
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_ABORT, 5'h10, 32'h5a);
      chk(word_o, 32'h5a000001);
   endtask
   task automatic s_commit_causes;
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_END);
      chk({commit_o, in_txn_o}, 2'b01);
      op(txabt_pkg::TXABT_OP_END);
      chk({commit_o, fence_o, discard_o}, 3'b110);
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_END);
      chk({commit_o, fence_o}, 2'b11);
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_NONE, 5'h01);
      chk({discard_o, word_o}, 33'h1_00000026);
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_NONE, 5'h02);
      chk(word_o, 32'h00000008);
   endtask
   task automatic s_always_suspend;
      txabt_pkg::txabt_op_t c;
      for (c = txabt_pkg::TXABT_OP_IDQUERY; c <= txabt_pkg::TXABT_OP_ENCL_USR; c = c.next()) begin
         op(txabt_pkg::TXABT_OP_BEGIN);
         op(c);
         chk({discard_o, in_txn_o, word_o}, 34'h2_00000000);
      end
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_SUSPEND);
      op(txabt_pkg::TXABT_OP_LOAD);
      chk(comb_q, 1'b0);
      op(txabt_pkg::TXABT_OP_RESUME);
      op(txabt_pkg::TXABT_OP_LOAD);
      chk(comb_q, 1'b1);
      op(txabt_pkg::TXABT_OP_SUSPEND);
      op(txabt_pkg::TXABT_OP_SUSPEND);
      chk({discard_o, in_txn_o}, 2'b10);
      for (c = txabt_pkg::TXABT_OP_BEGIN; c <= txabt_pkg::TXABT_OP_END; c = c.next()) begin
         op(txabt_pkg::TXABT_OP_BEGIN);
         op(txabt_pkg::TXABT_OP_SUSPEND);
         op(c);
         chk({discard_o, in_txn_o, commit_o}, 3'b100);
      end
   endtask
   task automatic s_direction;
      op(txabt_pkg::TXABT_OP_SET_DIR);
      chk(df_o, 1'b1);
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_SET_DIR);
      chk({in_txn_o, discard_o, df_o}, 3'b101);
      op(txabt_pkg::TXABT_OP_END);
      chk(commit_o, 1'b1);
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_CLEAR_DIR);
      chk({in_txn_o, discard_o, df_o}, 3'b011);
      op(txabt_pkg::TXABT_OP_CLEAR_DIR);
      chk(df_o, 1'b0);
   endtask
   task automatic s_debug;
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_NONE, 5'h04);
      chk({discard_o, redir_o, rollback_o, word_o}, 35'h6_00000010);
      wb(1'b1, `TXABT_OFS_DBGCTL, 32'h1 << `TXABT_DBGCTL_ADV);
      op(txabt_pkg::TXABT_OP_BEGIN);
      op(txabt_pkg::TXABT_OP_NONE, 5'h08);
      chk({redir_o, rollback_o, word_o}, 34'h2_00000010);
      wb(1'b1, `TXABT_OFS_DBGCTL, (32'h1 << `TXABT_DBGCTL_ADV) | (32'h1 << 31));
      op(txabt_pkg::TXABT_OP_BEGIN, 5'h0, 32'h42);
      op(txabt_pkg::TXABT_OP_NONE, 5'h08);
      chk({discard_o, redir_o, rollback_o, deliver_o}, 4'b1011);
      chk(word_o, 32'h00000042);
      wb(1'b0, `TXABT_OFS_DBGSTAT, 32'h0);
      chk(rd, `TXABT_DBGSTAT_RST & ~(32'h1 << `TXABT_DBGSTAT_TXN));
      wb(1'b0, `TXABT_OFS_COMMITS, 32'h0);
      chk(rd, 32'd3);
      wb(1'b0, `TXABT_OFS_EVENT, 32'h0);
      chk(rd, 32'h3);
      wb(1'b1, `TXABT_OFS_EVENT, 32'h3);
      wb(1'b0, `TXABT_OFS_EVENT, 32'h0);
      chk(rd, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Clock at 20 MHz
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Reset, then the scenarios in turn
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, op_valid_i} = 5'b10000;
      {wb_adr_i, op_arg_i, wb_sel_i, wb_dat_i, status_word_i, ev} = '0;
      op_code_i = txabt_pkg::TXABT_OP_NONE;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      s_reset();
      s_explicit();
      s_commit_causes();
      s_always_suspend();
      s_direction();
      s_debug();
      close_out();
   end
endmodule
